/* design/dvdl_pkg.sv */
// Constants shared by the dual variable delay line and its lane module.
// Assumes a single clock domain and control from same-clock logic.
package dvdl_pkg;

	// Width of one data lane and of the whole data word
	localparam int LANE_WIDTH = 4;
	localparam int WORD_WIDTH = 2 * LANE_WIDTH;

	// Internal chain stages per lane, ahead of the output stage
	localparam int STAGE_COUNT = 17;

	// Length code width and the delay range that it spans
	localparam int CODE_WIDTH = 4;
	localparam int MIN_DELAY = 3;
	localparam int MAX_DELAY = 18;

	// Length code that yields the longest delay
	localparam logic [CODE_WIDTH-1:0] CODE_LONGEST = 4'hF;

	// Reset values of the sampled controls
	localparam logic [CODE_WIDTH-1:0] LENGTH_RESET = 4'h0;
	localparam logic MODE_RESET = 1'b0;

	// Mode values: both lanes variable, or upper lane fixed
	localparam logic MODE_BOTH_VARIABLE = 1'b0;
	localparam logic MODE_UPPER_FIXED = 1'b1;

	// Output stage value after reset
	localparam logic [LANE_WIDTH-1:0] OUT_RESET = 4'h0;

	// Cycles after reset before every stage holds defined data
	localparam int WARM_CYCLES = MAX_DELAY + 2;
	localparam int WARM_WIDTH = 5;

endpackage

/* design/dvdl_lane.sv */
// One delay lane: a chain of stages plus a selected output stage.
// Assumes the select code is already registered by the caller.
`timescale 1ns/100ps

module dvdl_lane #(
	parameter int WIDTH = dvdl_pkg::LANE_WIDTH,
	parameter int STAGES = dvdl_pkg::STAGE_COUNT
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [WIDTH-1:0] laneIn,
	input wire logic [dvdl_pkg::CODE_WIDTH-1:0] selCode,
	output logic [WIDTH-1:0] laneOut
);
	import dvdl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Chain storage, index 0 is the first stage
	logic [WIDTH-1:0] stageReg [STAGES];
	// Value picked for the output stage
	logic [WIDTH-1:0] pickedStage;
	// Output stage
	logic [WIDTH-1:0] outReg;

	// Code 0 picks the second stage, so the shortest path is three edges
	assign pickedStage = stageReg[32'(selCode) + 1];

	////////////////////////////////////////////////////////////////////////
	// First stage captures the lane input on every edge; no reset on
	// purpose, so neither reset nor control changes disturb the data
	always_ff @(posedge clk_sys) begin
		stageReg[0] <= laneIn;
	end

	// Remaining stages each take their predecessor
	genvar gi;
	generate
		for (gi = 1; gi < STAGES; gi++) begin : g_chain
			always_ff @(posedge clk_sys) begin
				stageReg[gi] <= stageReg[gi-1];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Output stage; reset only so the pins show a known value early
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			outReg <= OUT_RESET;
		end else begin
			outReg <= pickedStage;
		end
	end

	assign laneOut = outReg;

endmodule

/* design/dvdl_top.sv */
// Dual variable delay line: two 4-bit lanes, one clock, shared controls.
// Assumes data and controls come from logic on clk_sys, so they need no
// synchroniser; downstream logic samples the outputs on the same clock.
//
// Overview of operation
// - Two independent 4-bit lanes, low and high nibble
// - One clock and shared controls for both
// - Variable delay of 3 to 18 clocks
// - Seventeen chain stages advance every rising edge
// - Mux picks stage two..seventeen into output stage
// - Shortest path is three stages, three clocks
// - Mode 0 delays both lanes by code
// - Mode 1 fixes upper lane at 18
// - Mode 1 keeps lower lane following code
// - Delay equals length code plus three
// - Code and mode sampled every rising edge outside reset
// - Control changes never disturb stored stage data
`timescale 1ns/100ps

module dvdl_top (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [dvdl_pkg::LANE_WIDTH-1:0] lower_lane_in,
	input wire logic [dvdl_pkg::LANE_WIDTH-1:0] upper_lane_in,
	input wire logic [dvdl_pkg::CODE_WIDTH-1:0] delay_length_code,
	input wire logic upperFixedMode,
	output logic [dvdl_pkg::LANE_WIDTH-1:0] lower_lane_out,
	output logic [dvdl_pkg::LANE_WIDTH-1:0] upper_lane_out
);
	import dvdl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	// Sampled copy of the length code
	logic [CODE_WIDTH-1:0] length_reg;
	// Sampled copy of the mode bit
	logic mode_reg;
	// Select code steering each lane's multiplexer
	logic [CODE_WIDTH-1:0] lowerSel;
	logic [CODE_WIDTH-1:0] upperSel;
	// Cycles since reset release, saturating; only assertions and covers read it
	logic [WARM_WIDTH-1:0] warm_reg;
	logic [WARM_WIDTH-1:0] warm_next;
	logic warmDone;

	////////////////////////////////////////////////////////////////////////
	// Select decoding, shared by both lanes
	function automatic logic [CODE_WIDTH-1:0] laneSelect(
		input logic [CODE_WIDTH-1:0] code,
		input logic mode,
		input logic isUpper
	);
		logic [CODE_WIDTH-1:0] result;
		result = code;
		// Upper lane ignores the code in fixed mode
		if (isUpper && (mode == MODE_UPPER_FIXED)) begin
			result = CODE_LONGEST;
		end
		return result;
	endfunction

	// Both multiplexers decode the same registered controls
	assign lowerSel = laneSelect(length_reg, mode_reg, 1'b0);
	assign upperSel = laneSelect(length_reg, mode_reg, 1'b1);

	////////////////////////////////////////////////////////////////////////
	// Control sampling on every edge outside reset; the multiplexers use these copies,
	// which adds one edge of latency before a new code takes effect
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			length_reg <= LENGTH_RESET;
			mode_reg <= MODE_RESET;
		end else begin
			length_reg <= delay_length_code;
			mode_reg <= upperFixedMode;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Lanes: low nibble and high nibble, each its own chain
	dvdl_lane #(
		.WIDTH(LANE_WIDTH),
		.STAGES(STAGE_COUNT)
	) u_lowerLane (
		.clk_sys(clk_sys),
		.srst(srst),
		.laneIn(lower_lane_in),
		.selCode(lowerSel),
		.laneOut(lower_lane_out)
	);

	dvdl_lane #(
		.WIDTH(LANE_WIDTH),
		.STAGES(STAGE_COUNT)
	) u_upperLane (
		.clk_sys(clk_sys),
		.srst(srst),
		.laneIn(upper_lane_in),
		.selCode(upperSel),
		.laneOut(upper_lane_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Warm-up counter for the checks below; stages are not reset, so the
	// output is meaningful only after the chain has been flushed
	assign warmDone = (warm_reg == WARM_WIDTH'(WARM_CYCLES));
	assign warm_next = warmDone ? warm_reg : warm_reg + 1'b1;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			warm_reg <= '0;
		end else begin
			warm_reg <= warm_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	// Shortest code gives three clocks on the lower lane
	property p_lower_min;
		@(posedge clk_sys) disable iff (srst)
		(warmDone && ($past(length_reg) == 4'h0))
			|-> (lower_lane_out == $past(lower_lane_in, 3));
	endproperty
	a_lower_min: assert property (p_lower_min)
		else $error("lower lane not delayed by 3 at code 0");

	// Longest code gives eighteen clocks on the lower lane
	property p_lower_max;
		@(posedge clk_sys) disable iff (srst)
		(warmDone && ($past(length_reg) == 4'hF))
			|-> (lower_lane_out == $past(lower_lane_in, 18));
	endproperty
	a_lower_max: assert property (p_lower_max)
		else $error("lower lane not delayed by 18 at code 15");

	// A middle code: delay is the code plus three
	property p_lower_mid;
		@(posedge clk_sys) disable iff (srst)
		(warmDone && ($past(length_reg) == 4'h7))
			|-> (lower_lane_out == $past(lower_lane_in, 10));
	endproperty
	a_lower_mid: assert property (p_lower_mid)
		else $error("lower lane not delayed by 10 at code 7");

	// Both-variable mode: upper lane follows the code too
	property p_upper_variable;
		@(posedge clk_sys) disable iff (srst)
		(warmDone && !$past(mode_reg) && ($past(length_reg) == 4'h1))
			|-> (upper_lane_out == $past(upper_lane_in, 4));
	endproperty
	a_upper_variable: assert property (p_upper_variable)
		else $error("upper lane not following code in mode 0");

	// Fixed mode: upper lane is eighteen clocks whatever the code
	property p_upper_fixed;
		@(posedge clk_sys) disable iff (srst)
		(warmDone && $past(mode_reg))
			|-> (upper_lane_out == $past(upper_lane_in, 18));
	endproperty
	a_upper_fixed: assert property (p_upper_fixed)
		else $error("upper lane not fixed at 18 in mode 1");

	// Fixed mode: lower lane still follows the code
	property p_lower_in_fixed;
		@(posedge clk_sys) disable iff (srst)
		(warmDone && $past(mode_reg) && ($past(length_reg) == 4'h2))
			|-> (lower_lane_out == $past(lower_lane_in, 5));
	endproperty
	a_lower_in_fixed: assert property (p_lower_in_fixed)
		else $error("lower lane not following code in mode 1");

	// Controls reach the sampled copies one edge later
	property p_ctrl_sampled;
		@(posedge clk_sys) disable iff (srst)
		1'b1 |=> ((length_reg == $past(delay_length_code))
			&& (mode_reg == $past(upperFixedMode)));
	endproperty
	a_ctrl_sampled: assert property (p_ctrl_sampled)
		else $error("controls not sampled on the clock edge");

	// Right after a code jump the new delay is exact, so the chain
	// contents were not disturbed by the change
	property p_change_keeps_data;
		@(posedge clk_sys) disable iff (srst)
		(warmDone && ($past(length_reg, 2) == 4'h0)
			&& ($past(length_reg) == 4'hF))
			|-> (lower_lane_out == $past(lower_lane_in, 18));
	endproperty
	a_change_keeps_data: assert property (p_change_keeps_data)
		else $error("code change disturbed stored data");

	// Lanes share controls: in mode 0 both see the same delay
	property p_lanes_shared;
		@(posedge clk_sys) disable iff (srst)
		(warmDone && !$past(mode_reg) && ($past(length_reg) == 4'h3))
			|-> ((lower_lane_out == $past(lower_lane_in, 6))
			&& (upper_lane_out == $past(upper_lane_in, 6)));
	endproperty
	a_lanes_shared: assert property (p_lanes_shared)
		else $error("lanes do not share controls in mode 0");

	////////////////////////////////////////////////////////////////////////
	// Coverage of the main scenarios

	// Fixed mode in use after warm-up
	property p_cov_fixed;
		@(posedge clk_sys) disable iff (srst)
		warmDone && mode_reg && (length_reg == 4'h0);
	endproperty
	c_cov_fixed: cover property (p_cov_fixed);

	// Longest code in both-variable mode
	property p_cov_longest;
		@(posedge clk_sys) disable iff (srst)
		warmDone && !mode_reg && (length_reg == CODE_LONGEST);
	endproperty
	c_cov_longest: cover property (p_cov_longest);

	// Mode switch with a code change on the same edge
	property p_cov_switch;
		@(posedge clk_sys) disable iff (srst)
		warmDone && $changed(mode_reg) && $changed(length_reg);
	endproperty
	c_cov_switch: cover property (p_cov_switch);

endmodule

/* test/dvdl_source.sv */
// Upstream model: a new data word on both lanes every clock cycle.
// Assumes one clock; words change a fixed 1 ns after each rising edge.
`timescale 1ns/100ps

module dvdl_source (
	input wire logic clk_sys,
	output logic [dvdl_pkg::LANE_WIDTH-1:0] lowerData,
	output logic [dvdl_pkg::LANE_WIDTH-1:0] upperData
);
	import dvdl_pkg::*;
	////////////////////////////////////////////////////////////////////
	// 8-bit pattern with a long period, so an 18-cycle shift never aliases
	logic [7:0] lfsrReg = 8'h01;
	// Nibbles differ, so a swapped lane shows up at once
	assign lowerData = lfsrReg[3:0];
	assign upperData = lfsrReg[7:4];
	// Back-to-back words, no idle cycles
	always @(posedge clk_sys) begin
		lfsrReg <= #1 {lfsrReg[6:0],
			lfsrReg[7] ^ lfsrReg[5] ^ lfsrReg[4] ^ lfsrReg[3]};
	end
endmodule

/* test/dvdl_top_test.sv */
// Self-checking bench for the dual variable delay line.
// Assumes dvdl_source feeds data; the bench drives controls and reset.
`timescale 1ns/100ps

module dvdl_top_test;
	import dvdl_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [CODE_WIDTH-1:0] lenCode = 4'h0;
	logic modeBit = 1'b0;
	logic [LANE_WIDTH-1:0] lowIn;
	logic [LANE_WIDTH-1:0] upIn;
	logic [LANE_WIDTH-1:0] lowOut;
	logic [LANE_WIDTH-1:0] upOut;
	int err_total = 0;
	int num_checks = 0;
	int edgeNum = 0;
	int dLow;
	int dUp;
	// Expected lane values for the edge being judged
	logic [LANE_WIDTH-1:0] expLow;
	logic [LANE_WIDTH-1:0] expUp;
	// What the block sampled at each edge, indexed by edge mod 256
	logic [LANE_WIDTH-1:0] lowHist [256];
	logic [LANE_WIDTH-1:0] upHist [256];
	logic [CODE_WIDTH-1:0] codeHist [256];
	logic modeHist [256];
	logic rstHist [256];

	////////////////////////////////////////////////////////////////////
	// Clock, partner and block
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) edgeNum <= edgeNum + 1;

	dvdl_source partner (.clk_sys(clk_sys), .lowerData(lowIn),
		.upperData(upIn));

	dvdl_top DUT (.clk_sys(clk_sys), .srst(srst), .lower_lane_in(lowIn),
		.upper_lane_in(upIn), .delay_length_code(lenCode),
		.upperFixedMode(modeBit), .lower_lane_out(lowOut),
		.upper_lane_out(upOut));

	////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic check(input string what, input logic [3:0] seen,
		input logic [3:0] expected);
		num_checks++;
		if (seen !== expected) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, expected,
				seen);
		end
	endtask

	// Mid-cycle: log inputs for the next edge, judge the last edge.
	// Output after edge n uses controls taken at edge n-1 and data
	// taken at edge n+1-D; a reset edge clears the output stage and the sampled controls.
	always @(negedge clk_sys) begin
		lowHist[(edgeNum + 1) % 256] = lowIn;
		upHist[(edgeNum + 1) % 256] = upIn;
		codeHist[(edgeNum + 1) % 256] = srst ? LENGTH_RESET : lenCode;
		modeHist[(edgeNum + 1) % 256] = srst ? MODE_RESET : modeBit;
		rstHist[(edgeNum + 1) % 256] = srst;
		if (edgeNum >= 24) begin
			if (rstHist[edgeNum % 256]) begin
				// Reset edge: output stage cleared
				check("lower reset", lowOut, OUT_RESET);
				check("upper reset", upOut, OUT_RESET);
			end else begin
				dLow = int'(codeHist[(edgeNum - 1) % 256]) + MIN_DELAY;
				dUp = modeHist[(edgeNum - 1) % 256] ? MAX_DELAY : dLow;
				expLow = lowHist[(edgeNum + 1 - dLow) % 256];
				expUp = upHist[(edgeNum + 1 - dUp) % 256];
				check("lower out", lowOut, expLow);
				check("upper out", upOut, expUp);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic run_cycles(input int cnt);
		repeat (cnt) @(posedge clk_sys);
	endtask

	// Every length code in mode 0, held long enough to flush
	task automatic test_sweep();
		for (int c = 0; c < 16; c++) begin
			@(posedge clk_sys);
			#1 lenCode = 4'(c);
			modeBit = MODE_BOTH_VARIABLE;
			run_cycles(20);
		end
		$display("test_sweep done, mismatches %0d", err_total);
	endtask

	// Upper lane fixed while lower follows the code, both end codes too;
	// the jump from shortest to longest code shows the chain kept intact
	task automatic test_upper_fixed();
		logic [3:0] codes [4] = '{4'h0, 4'hF, 4'h7, 4'h3};
		foreach (codes[i]) begin
			@(posedge clk_sys);
			#1 lenCode = codes[i];
			modeBit = MODE_UPPER_FIXED;
			run_cycles(22);
		end
		$display("test_upper_fixed done, mismatches %0d", err_total);
	endtask

	// Code changes every cycle, mode every third; stored data must stay intact
	task automatic test_fast_switch();
		for (int i = 0; i < 64; i++) begin
			@(posedge clk_sys);
			#1 lenCode = 4'(i) ^ 4'h5;
			modeBit = (i % 6) < 3;
		end
		run_cycles(20);
		$display("test_fast_switch done, mismatches %0d", err_total);
	endtask

	// Reset in mid-run: data from before reset still flows out after
	task automatic test_reset_mid();
		@(posedge clk_sys);
		#1 lenCode = 4'h9;
		modeBit = MODE_UPPER_FIXED;
		run_cycles(20);
		#1 srst = 1'b1;
		run_cycles(2);
		#1 srst = 1'b0;
		run_cycles(25);
		$display("test_reset_mid done, mismatches %0d", err_total);
	endtask

	////////////////////////////////////////////////////////////////////
	// Verdict and run control
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Hang guard, far beyond the planned run
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		#1 srst = 1'b0;
		run_cycles(20);
		test_sweep();
		test_upper_fixed();
		test_fast_switch();
		test_reset_mid();
		wrap_up();
	end
endmodule
